// ==== logic/phy_pwr_pkg.sv ====
// Shared constants and types for the transceiver power-mode controller.
package phy_pwr_pkg;
   // Management register addresses.
   localparam logic [4:0] REG_BASIC_CTRL = 5'h00;
   localparam logic [4:0] REG_PLL_CTRL = 5'h10;
   localparam logic [4:0] REG_OSC_CTRL = 5'h11;
   localparam logic [4:0] REG_ENERGY_DETECT_POWERDOWN_CTRL = 5'h18;
   localparam logic [4:0] REG_PHY_CTRL2 = 5'h1f;
   // Field positions.
   localparam int BIT_SOFT_RESET = 15;
   localparam int BIT_AN_ENABLE = 12;
   localparam int BIT_POWER_DOWN = 11;
   localparam int BIT_PLL_AUTO_OFF = 4;
   localparam int BIT_SLOW_OSC = 5;
   localparam int BIT_ENERGY_DETECT_POWERDOWN_OFF = 11;
   localparam int BIT_POWER_SAVE = 10;
   // Reset values of the control bits.
   localparam logic RST_AN_ENABLE = 1'b1;
   localparam logic RST_POWER_DOWN = 1'b0;
   localparam logic RST_PLL_AUTO_OFF = 1'b0;
   localparam logic RST_SLOW_OSC = 1'b0;
   localparam logic RST_ENERGY_DETECT_POWERDOWN_OFF = 1'b1;
   localparam logic RST_POWER_SAVE = 1'b0;
   // Management frame figures.
   localparam logic [5:0] PREAMBLE_ONES = 6'h20;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   // Link pulse interval in energy-detect power-down.
   localparam longint LINK_PULSE_MS = 16;
   localparam longint MCLK_PERIOD_NS = 5;
   localparam longint LINK_PULSE_CYCLES = LINK_PULSE_MS * 1000000 / MCLK_PERIOD_NS;

   typedef enum logic [2:0] {
      MODE_NORMAL = 3'h0,
      MODE_PSAVE = 3'h1,
      MODE_ENERGY_DETECT_POWERDOWN = 3'h3,
      MODE_ENERGY_DETECT_POWERDOWN_PLL_OFF = 3'h2,
      MODE_POWER_DOWN = 3'h6,
      MODE_LOWEST = 3'h7
   } power_mode_t;

   typedef enum logic [1:0] {
      FR_PREAMBLE = 2'h0,
      FR_HEADER = 2'h1,
      FR_TURN = 2'h3,
      FR_DATA = 2'h2
   } frame_state_t;

   typedef struct packed {
      logic tx;
      logic energy_det;
      logic pll;
      logic rx;
      logic core;
   } gate_t;

   typedef struct packed {
      logic en;
      logic [4:0] addr;
      logic [15:0] data;
   } reg_wr_t;
endpackage

// ==== logic/mgmt_serial_slave.sv ====
// Serial management frame slave, sampling the management clock on mclk.
`timescale 1ns/1ps
module mgmt_serial_slave import phy_pwr_pkg::*; (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Pins
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [4:0] phy_addr,
   // Register side
   output logic [4:0] reg_addr,
   input wire logic [15:0] reg_rd_data,
   output reg_wr_t reg_wr
);
   logic [1:0] mdc_sync;
   logic [1:0] mdio_sync;
   logic mdc_last;
   frame_state_t state;
   logic [5:0] ones;
   logic [3:0] cnt;
   logic [15:0] sr;
   logic is_read;

   // Both pins pass two flops; the second stage alone feeds the edge detector.
   wire mdc_rise = mdc_sync[1] & ~mdc_last;
   wire mdc_fall = ~mdc_sync[1] & mdc_last;
   wire bit_in = mdio_sync[1];
   wire [12:0] header = {sr[11:0], bit_in};
   wire header_ok = header[12] && header[9:5] == phy_addr &&
                    (header[11:10] == OP_READ || header[11:10] == OP_WRITE);
   wire [15:0] next_sr = {sr[14:0], bit_in};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mdc_sync <= 2'h0;
         mdio_sync <= 2'h0;
         mdc_last <= 1'b0;
      end else begin
         mdc_sync <= {mdc_sync[0], mdc};
         mdio_sync <= {mdio_sync[0], mdio_in};
         mdc_last <= mdc_sync[1];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= FR_PREAMBLE;
         ones <= 6'h0;
         cnt <= 4'h0;
         sr <= 16'h0;
         is_read <= 1'b0;
         reg_addr <= 5'h0;
         reg_wr <= '0;
      end else begin
         reg_wr.en <= 1'b0;
         if (mdc_rise) begin
            unique case (state)
               FR_PREAMBLE: begin
                  if (bit_in) begin
                     ones <= (ones == PREAMBLE_ONES) ? ones : ones + 6'h1;
                  end else begin
                     ones <= 6'h0;
                     cnt <= 4'h0;
                     if (ones == PREAMBLE_ONES) begin
                        state <= FR_HEADER;
                     end
                  end
               end
               FR_HEADER: begin
                  sr <= next_sr;
                  cnt <= cnt + 4'h1;
                  if (cnt == 4'hc) begin
                     cnt <= 4'h0;
                     is_read <= header[11:10] == OP_READ;
                     reg_addr <= header[4:0];
                     state <= header_ok ? FR_TURN : FR_PREAMBLE;
                  end
               end
               FR_TURN: begin
                  cnt <= cnt + 4'h1;
                  if (cnt == 4'h1) begin
                     cnt <= 4'h0;
                     sr <= reg_rd_data;
                     state <= FR_DATA;
                  end
               end
               FR_DATA: begin
                  cnt <= cnt + 4'h1;
                  if (!is_read) begin
                     sr <= next_sr;
                  end
                  if (cnt == 4'hf) begin
                     // A write acts as soon as its last data bit is in. R13
                     reg_wr <= '{en: !is_read, addr: reg_addr, data: next_sr};
                     state <= FR_PREAMBLE;
                  end
               end
            endcase
         end
      end
   end

   // Read data changes on the falling edge so the controller samples it stable.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mdio_out <= 1'b0;
         mdio_oe <= 1'b0;
      end else if (mdc_fall) begin
         mdio_oe <= is_read && ((state == FR_TURN && cnt == 4'h1) || state == FR_DATA);
         mdio_out <= (state == FR_DATA) ? sr[4'hf - cnt] : 1'b0;
      end
   end
endmodule

// ==== logic/link_pulse_timer.sv ====
// Periodic link pulse generator for energy-detect power-down.
`timescale 1ns/1ps
module link_pulse_timer #(
   parameter int unsigned INTERVAL = 3200000
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic [1:0] stretch,
   output logic pulse
);
   logic [33:0] count;
   wire [33:0] limit = 34'(INTERVAL) << stretch;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 34'h0;
         pulse <= 1'b0;
      end else begin
         pulse <= run && count >= limit - 34'h1;
         if (!run || count >= limit - 34'h1) begin
            count <= 34'h0;
         end else begin
            count <= count + 34'h1;
         end
      end
   end
endmodule

// ==== logic/phy_power_mode_control.sv ====
// Power-mode controller of the transceiver with its management register bits.
//
// Functional notes
// R01: Power-save bit active only with autoneg, no link.
// R02: Power-save keeps only transmitter, energy detector, PLL.
// R03: Power-save enable resets to disabled.
// R04: Energy-detect down enabled low, needs autoneg, no link.
// R05: PLL auto-off turns PLL off in energy-detect down.
// R06: Energy-detect down keeps sending periodic link pulses.
// R07: Energy-detect disable bit resets to one.
// R08: Power-down bit stops all but management interface.
// R09: Clearing power-down bit leaves power-down.
// R10: Slow-oscillator bit replaces reference clock input.
// R11: Slow oscillator plus power-down gives lowest state.
// R12: Exit: clear oscillator, clear power-down, soft reset.
// R13: Control bits act when their write frame ends.
`timescale 1ns/1ps
module phy_power_mode_control import phy_pwr_pkg::*; #(
   parameter int unsigned PULSE_CYCLES = 32'(LINK_PULSE_CYCLES)
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Management pins
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [4:0] phy_addr,
   // Transceiver status and settings
   input wire logic link_up,
   input wire logic [1:0] pulse_stretch,
   // Power control
   output gate_t gates,
   output power_mode_t power_mode,
   output logic crystal_clock_input_off,
   output logic link_pulse,
   output logic soft_reset
);
   logic an_enable;
   logic power_down;
   logic pll_auto_off;
   logic slow_osc;
   logic energy_detect_powerdown_off;
   logic power_save;
   logic pulse_raw;
   logic [4:0] reg_addr;
   reg_wr_t reg_wr;
   logic [15:0] reg_rd_data;
   power_mode_t next_mode;
   gate_t next_gates;

   mgmt_serial_slave u_slave (
      .mclk(mclk),
      .rst_n(rst_n),
      .mdc(mdc),
      .mdio_in(mdio_in),
      .mdio_out(mdio_out),
      .mdio_oe(mdio_oe),
      .phy_addr(phy_addr),
      .reg_addr(reg_addr),
      .reg_rd_data(reg_rd_data),
      .reg_wr(reg_wr)
   );

   // Register write decode.
   wire wr_basic = reg_wr.en && reg_wr.addr == REG_BASIC_CTRL;
   wire wr_pll = reg_wr.en && reg_wr.addr == REG_PLL_CTRL;
   wire wr_osc = reg_wr.en && reg_wr.addr == REG_OSC_CTRL;
   wire wr_energy_detect_powerdown = reg_wr.en && reg_wr.addr == REG_ENERGY_DETECT_POWERDOWN_CTRL;
   wire wr_ctrl2 = reg_wr.en && reg_wr.addr == REG_PHY_CTRL2;
   wire do_soft_reset = wr_basic && reg_wr.data[BIT_SOFT_RESET];

   // Read-back; unimplemented bits and addresses read as zero.
   wire [15:0] rd_basic = 16'(an_enable) << BIT_AN_ENABLE | 16'(power_down) << BIT_POWER_DOWN;
   wire [15:0] rd_pll = 16'(pll_auto_off) << BIT_PLL_AUTO_OFF;
   wire [15:0] rd_osc = 16'(slow_osc) << BIT_SLOW_OSC;
   wire [15:0] rd_energy_detect_powerdown = 16'(energy_detect_powerdown_off) << BIT_ENERGY_DETECT_POWERDOWN_OFF;
   wire [15:0] rd_ctrl2 = 16'(power_save) << BIT_POWER_SAVE;
   assign reg_rd_data = (reg_addr == REG_BASIC_CTRL) ? rd_basic :
                        (reg_addr == REG_PLL_CTRL) ? rd_pll :
                        (reg_addr == REG_OSC_CTRL) ? rd_osc :
                        (reg_addr == REG_ENERGY_DETECT_POWERDOWN_CTRL) ? rd_energy_detect_powerdown :
                        (reg_addr == REG_PHY_CTRL2) ? rd_ctrl2 : 16'h0;

   // Soft reset returns every control bit to its power-up value. R12
   // It is a synchronous branch so the asynchronous reset term stays a bare pin.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         an_enable <= RST_AN_ENABLE;
         power_down <= RST_POWER_DOWN;
         pll_auto_off <= RST_PLL_AUTO_OFF;
         slow_osc <= RST_SLOW_OSC;
         energy_detect_powerdown_off <= RST_ENERGY_DETECT_POWERDOWN_OFF; // R07
         power_save <= RST_POWER_SAVE; // R03
      end else if (do_soft_reset) begin
         an_enable <= RST_AN_ENABLE;
         power_down <= RST_POWER_DOWN;
         pll_auto_off <= RST_PLL_AUTO_OFF;
         slow_osc <= RST_SLOW_OSC;
         energy_detect_powerdown_off <= RST_ENERGY_DETECT_POWERDOWN_OFF; // R07
         power_save <= RST_POWER_SAVE; // R03
      end else begin
         if (wr_basic) begin
            an_enable <= reg_wr.data[BIT_AN_ENABLE];
            power_down <= reg_wr.data[BIT_POWER_DOWN]; // R08 R09 R13
         end
         if (wr_pll) begin
            pll_auto_off <= reg_wr.data[BIT_PLL_AUTO_OFF];
         end
         if (wr_osc) begin
            slow_osc <= reg_wr.data[BIT_SLOW_OSC];
         end
         if (wr_energy_detect_powerdown) begin
            energy_detect_powerdown_off <= reg_wr.data[BIT_ENERGY_DETECT_POWERDOWN_OFF];
         end
         if (wr_ctrl2) begin
            power_save <= reg_wr.data[BIT_POWER_SAVE];
         end
      end
   end

   // Mode selection; power-down overrides the cable-dependent modes.
   wire no_link_an = an_enable && !link_up;
   wire energy_detect_powerdown_on = no_link_an && !energy_detect_powerdown_off; // R04
   wire psave_on = no_link_an && power_save; // R01
   assign next_mode = power_down ? (slow_osc ? MODE_LOWEST : MODE_POWER_DOWN) : // R11
                      energy_detect_powerdown_on ? (pll_auto_off ? MODE_ENERGY_DETECT_POWERDOWN_PLL_OFF : MODE_ENERGY_DETECT_POWERDOWN) :
                      psave_on ? MODE_PSAVE : MODE_NORMAL;

   always_comb begin
      unique case (next_mode)
         MODE_NORMAL: next_gates = '{tx: 1'b1, energy_det: 1'b1, pll: 1'b1, rx: 1'b1, core: 1'b1};
         MODE_PSAVE: next_gates = '{tx: 1'b1, energy_det: 1'b1, pll: 1'b1, rx: 1'b0, core: 1'b0}; // R02
         MODE_ENERGY_DETECT_POWERDOWN: next_gates = '{tx: 1'b1, energy_det: 1'b1, pll: 1'b1, rx: 1'b0, core: 1'b0};
         MODE_ENERGY_DETECT_POWERDOWN_PLL_OFF: next_gates = '{tx: 1'b1, energy_det: 1'b1, pll: 1'b0, rx: 1'b0, core: 1'b0}; // R05
         MODE_POWER_DOWN: next_gates = '0; // R08
         MODE_LOWEST: next_gates = '0; // R11
         default: next_gates = '0;
      endcase
   end

   // Gates and mode change together so no sub-block sees a half-applied mode.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         power_mode <= MODE_NORMAL;
         gates <= '{tx: 1'b1, energy_det: 1'b1, pll: 1'b1, rx: 1'b1, core: 1'b1};
         crystal_clock_input_off <= 1'b0;
         soft_reset <= 1'b0;
         link_pulse <= 1'b0;
      end else begin
         power_mode <= next_mode;
         gates <= next_gates;
         crystal_clock_input_off <= slow_osc; // R10
         soft_reset <= do_soft_reset;
         link_pulse <= pulse_raw;
      end
   end

   // Link pulses keep flowing while the cable is idle in energy-detect down.
   wire pulse_run = power_mode == MODE_ENERGY_DETECT_POWERDOWN || power_mode == MODE_ENERGY_DETECT_POWERDOWN_PLL_OFF; // R06

   link_pulse_timer #(.INTERVAL(PULSE_CYCLES)) u_pulse (
      .mclk(mclk),
      .rst_n(rst_n),
      .run(pulse_run),
      .stretch(pulse_stretch),
      .pulse(pulse_raw)
   );

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_psave_needs_idle: assert property (power_mode == MODE_PSAVE |->
      $past(an_enable && !link_up && power_save)) // R01
      else $error("power-save mode without autoneg, idle cable and enable");
   a_psave_gate_set: assert property (power_mode == MODE_PSAVE |->
      gates.tx && gates.energy_det && gates.pll && !gates.rx && !gates.core) // R02
      else $error("power-save mode gates wrong sub-blocks");
   a_reset_defaults: assert property (soft_reset |->
      !power_save && energy_detect_powerdown_off && !power_down) // R03
      else $error("soft reset left control bits off their defaults");
   a_energy_detect_powerdown_low_enable: assert property (wr_energy_detect_powerdown && !reg_wr.data[BIT_ENERGY_DETECT_POWERDOWN_OFF] && !power_down
      && !do_soft_reset ##1 an_enable && !link_up && !power_down |=>
      power_mode inside {MODE_ENERGY_DETECT_POWERDOWN, MODE_ENERGY_DETECT_POWERDOWN_PLL_OFF}) // R04
      else $error("energy-detect down not entered after enable write");
   a_pll_auto_off: assert property (power_mode == MODE_ENERGY_DETECT_POWERDOWN_PLL_OFF |->
      !gates.pll && gates.tx && gates.energy_det && $past(pll_auto_off)) // R05
      else $error("PLL gating wrong in energy-detect down");
   a_pulse_only_energy_detect_powerdown: assert property (link_pulse |->
      $past(power_mode, 2) inside {MODE_ENERGY_DETECT_POWERDOWN, MODE_ENERGY_DETECT_POWERDOWN_PLL_OFF}) // R06
      else $error("link pulse outside energy-detect down");
   a_pd_entry: assert property (wr_basic && reg_wr.data[BIT_POWER_DOWN]
      && !reg_wr.data[BIT_SOFT_RESET] |-> ##2 gates == '0) // R08
      else $error("power-down write did not stop sub-blocks in two cycles");
   a_pd_exit: assert property ($fell(power_down) && !soft_reset |=>
      !(power_mode inside {MODE_POWER_DOWN, MODE_LOWEST})) // R09
      else $error("power-down not left after bit cleared");
   a_osc_follows: assert property (slow_osc |=> crystal_clock_input_off) // R10
      else $error("reference clock not replaced by slow oscillator");
   a_lowest_state: assert property (power_mode == MODE_LOWEST |->
      crystal_clock_input_off && gates == '0) // R11
      else $error("lowest state without slow oscillator and full gating");
   a_write_acts: assert property (wr_osc |=> slow_osc == $past(reg_wr.data[BIT_SLOW_OSC])) // R13
      else $error("oscillator bit not taken at frame end");

   c_psave: cover property (power_mode == MODE_PSAVE);
   c_energy_detect_powerdown_pll_off: cover property (power_mode == MODE_ENERGY_DETECT_POWERDOWN_PLL_OFF ##[1:1000] link_pulse);
   c_lowest: cover property (power_mode == MODE_LOWEST);
   c_exit_reset: cover property (soft_reset ##1 power_mode == MODE_NORMAL);
endmodule

// ==== bench/mgmt_master_model.sv ====
// Station-management model that sends serial frames on the management pins.
`timescale 1ns/1ps
module mgmt_master_model (
   // Pins
   output logic mdc,
   output logic mdio_drv,
   output logic mdio_drv_oe,
   input wire logic mdio
);
   initial begin
      mdc = 1'b0;
      mdio_drv = 1'b1;
      mdio_drv_oe = 1'b0;
   end
   // One 80 ns bit: data moves while the clock is low, so it is settled at the rise.
   task automatic put_bit(input logic b, input logic drive, output logic seen);
      mdc = 1'b0;
      mdio_drv = b;
      mdio_drv_oe = drive;
      #40;
      mdc = 1'b1;
      seen = mdio;
      #40;
   endtask
   // The clock stands low between frames and the line is released to its pull-up.
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regn,
                        input logic [15:0] wdata, output logic [15:0] rdata);
      logic [13:0] head;
      logic wr;
      logic s;
      head = {2'b01, op, phy, regn};
      wr = (op == 2'h1);
      for (int i = 0; i < 32; i++) put_bit(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) put_bit(head[i], 1'b1, s);
      put_bit(1'b1, wr, s);
      put_bit(1'b0, wr, s);
      for (int i = 15; i >= 0; i--) begin
         put_bit(wdata[i], wr, s);
         rdata[i] = s;
      end
      mdc = 1'b0;
      mdio_drv_oe = 1'b0;
      #200;
   endtask
endmodule

// ==== bench/phy_power_mode_control_tb.sv ====
// Self-checking bench for the transceiver power-mode controller.
`timescale 1ns/1ps
module phy_power_mode_control_tb import phy_pwr_pkg::*;;
   localparam logic [4:0] PHY = 5'h03;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic mdc;
   logic mdio_drv;
   logic mdio_drv_oe;
   logic mdio_out;
   logic mdio_oe;
   wire logic mdio_line;
   logic link_up = 1'b0;
   logic [1:0] pulse_stretch = 2'h0;
   gate_t gates;
   power_mode_t power_mode;
   logic crystal_clock_input_off;
   logic link_pulse;
   logic soft_reset;
   int n_errors = 0;
   int n_checks = 0;
   int n_pulse = 0;
   int n_soft = 0;
   int p;
   logic [15:0] v;

   always #2.5 mclk = ~mclk;
   // The slave's drive wins over the master's; an idle line floats up to its pull-up level.
   assign mdio_line = mdio_oe ? mdio_out : (mdio_drv_oe ? mdio_drv : 1'b1);
   always @(posedge mclk) begin
      if (link_pulse === 1'b1) n_pulse++;
      if (soft_reset === 1'b1) n_soft++;
   end

   phy_power_mode_control #(.PULSE_CYCLES(40)) phy_power_mode_control_i (
      .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .phy_addr(PHY), .link_up(link_up), .pulse_stretch(pulse_stretch),
      .gates(gates), .power_mode(power_mode),
      .crystal_clock_input_off(crystal_clock_input_off), .link_pulse(link_pulse),
      .soft_reset(soft_reset));
   mgmt_master_model mgmt_master_model_i (
      .mdc(mdc), .mdio_drv(mdio_drv), .mdio_drv_oe(mdio_drv_oe), .mdio(mdio_line));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic mode_is(input power_mode_t m, input logic [4:0] g);
      check({13'h0, power_mode}, {13'h0, m});
      check({11'h0, gates}, {11'h0, g});
   endtask
   task automatic wr(input logic [4:0] r, input logic [15:0] d);
      logic [15:0] x;
      mgmt_master_model_i.frame(OP_WRITE, PHY, r, d, x);
   endtask
   task automatic rd(input logic [4:0] r, output logic [15:0] d);
      mgmt_master_model_i.frame(OP_READ, PHY, r, 16'hffff, d);
   endtask
   task automatic set_link(input logic l);
      @(negedge mclk);
      link_up = l;
      repeat (4) @(negedge mclk);
   endtask
   task automatic results();
      if (n_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // The whole sequence needs some 126 us; the limit leaves ample room.
   initial begin
      #450000;
      n_errors++;
      results();
   end

   initial begin
      repeat (12) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      mode_is(MODE_NORMAL, 5'h1f);
      check({15'h0, crystal_clock_input_off}, 16'h0000);
      rd(5'h1f, v); check(v, 16'h0000);
      rd(5'h18, v); check(v, 16'h0800);
      rd(5'h00, v); check(v, 16'h1000);
      rd(5'h05, v); check(v, 16'h0000);
      mgmt_master_model_i.frame(OP_WRITE, 5'h04, 5'h1f, 16'h0400, v);
      mode_is(MODE_NORMAL, 5'h1f);
      wr(5'h1f, 16'h0400);
      mode_is(MODE_PSAVE, 5'h1c);
      rd(5'h1f, v); check(v, 16'h0400);
      set_link(1'b1);
      mode_is(MODE_NORMAL, 5'h1f);
      set_link(1'b0);
      wr(5'h18, 16'h0000);
      check({13'h0, power_mode}, {13'h0, MODE_ENERGY_DETECT_POWERDOWN});
      wr(5'h10, 16'h0010);
      mode_is(MODE_ENERGY_DETECT_POWERDOWN_PLL_OFF, 5'h18);
      for (int s = 0; s < 3; s++) begin
         @(negedge mclk);
         pulse_stretch = 2'(s);
         repeat (400) @(posedge mclk);
         p = n_pulse;
         repeat (160 << s) @(posedge mclk);
         check(16'(n_pulse - p), 16'h0004);
      end
      wr(5'h00, 16'h0000);
      mode_is(MODE_NORMAL, 5'h1f);
      p = n_pulse;
      repeat (400) @(posedge mclk);
      check(16'(n_pulse - p), 16'h0000);
      wr(5'h00, 16'h1000);
      check({13'h0, power_mode}, {13'h0, MODE_ENERGY_DETECT_POWERDOWN_PLL_OFF});
      set_link(1'b1);
      mode_is(MODE_NORMAL, 5'h1f);
      set_link(1'b0);
      wr(5'h00, 16'h1800);
      mode_is(MODE_POWER_DOWN, 5'h00);
      p = n_pulse;
      rd(5'h00, v); check(v, 16'h1800);
      check(16'(n_pulse - p), 16'h0000);
      wr(5'h11, 16'h0020);
      check({15'h0, crystal_clock_input_off}, 16'h0001);
      mode_is(MODE_LOWEST, 5'h00);
      rd(5'h11, v); check(v, 16'h0020);
      // The exit runs in the documented order: oscillator, power-down, then reset.
      wr(5'h11, 16'h0000);
      check({15'h0, crystal_clock_input_off}, 16'h0000);
      mode_is(MODE_POWER_DOWN, 5'h00);
      wr(5'h00, 16'h1000);
      mode_is(MODE_ENERGY_DETECT_POWERDOWN_PLL_OFF, 5'h18);
      wr(5'h00, 16'h9800);
      check(16'(n_soft), 16'h0001);
      mode_is(MODE_NORMAL, 5'h1f);
      rd(5'h18, v); check(v, 16'h0800);
      rd(5'h10, v); check(v, 16'h0000);
      rd(5'h00, v); check(v, 16'h1000);
      results();
   end
endmodule
